/* logic/arpw_regs.svh */
// register offsets, field positions, reset values and counts for pwm
`ifndef ARPW_REGS_SVH
`define ARPW_REGS_SVH
`define ARPW_OFF_CAP_HIGH 8'h23
`define ARPW_OFF_CAP_LOW 8'h24
`define ARPW_OFF_CSR2 8'h25
`define ARPW_OFF_RLD2_HIGH 8'h27
`define ARPW_OFF_RLD2_LOW 8'h28
`define ARPW_OFF_DEAD 8'h29
`define ARPW_OFF_BRKEN 8'h2a
`define ARPW_OFF_DUTY0 8'h30
`define ARPW_OFF_POL 8'h38
`define ARPW_OFF_RLD1_HIGH 8'h39
`define ARPW_OFF_RLD1_LOW 8'h3a
`define ARPW_OFF_CNT2_HIGH 8'h3b
`define ARPW_OFF_CNT2_LOW 8'h3c
`define ARPW_CSR2_FORCE_OVERFLOW_TWO 7
`define ARPW_CSR2_FORCE_OVERFLOW_ONE 6
`define ARPW_CSR2_ICS 5
`define ARPW_CSR2_OVERFLOW_TWO_IRQ_ENABLE 4
`define ARPW_CSR2_OVERFLOW_TWO_FLAG 3
`define ARPW_CSR2_SEL2 2
`define ARPW_CSR2_TRANSFER_ENABLE_TWO 1
`define ARPW_CSR2_TRANSFER_ENABLE_ONE 0
`define ARPW_RST_CSR2 8'h03
`define ARPW_RST_BRKEN 2'h3
`define ARPW_DEAD_EN 7
`define ARPW_CNT_FULL 12'hfff
`endif

/* logic/arpw_pkg.sv */
// types shared by the pwm block
package arpw_pkg;
  typedef logic [11:0] arpw_count_type;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } arpw_bus_type;
  // dead-time phases for the channel 0/1 pair
  typedef enum logic [2:0] {
    ARPW_DT_IDLE = 3'b001,
    ARPW_DT_WAIT = 3'b010,
    ARPW_DT_RUN = 3'b100
  } arpw_dt_type;
endpackage

/* logic/arpw_top.sv */
// 12-bit autoreload pwm: counter 2, capture, break, transfer, dead time
`timescale 1ns/1ps
`default_nettype none
`include "arpw_regs.svh"
// Operation
// - any edge on chosen capture pin copies counter 1 into capture data.
// - capture happens only while capture flag is clear.
// - capture source select high takes the lite capture pin.
// - counter-2 break enable with active break governs selected 2,3.
// - counter-1 break enable governs 0,1, and 2,3 when unselected.
// - force two loads FFFh in counter 2, cleared cycle after overflow.
// - force one loads FFFh in counter 1, cleared cycle after overflow.
// - overflow-two irq high only while its enable and flag are set.
// - overflow-two flag set on counter 2 wrap, cleared by status read.
// - select high drives channels 2,3 from counter 2, else counter 1.
// - counter 2 holds while unselected, except for a force-two load of FFFh, and resumes from held value.
// - transfer two moves duty and polarity of 2,3 on counter-2 overflow.
// - transfer one moves 0,1 and unselected 2,3 on counter-1 overflow.
// - counter 2 reloads its reload value on every overflow.
// - counter-2 reload sets channel 2,3 period only when selected.
// - dead-time enable inserts dead time between channel 0 and 1.
// - dead time equals count field times one counter-1 clock period.
// - enabled dead time with zero count holds channels 0,1 at reset state.
module arpw_top
  import arpw_pkg::*;
#(
  parameter int CW = 12
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic tick1_i,
  input wire logic tick2_i,
  input wire logic timer_capture_pin_i,
  input wire logic lite_capture_pin_i,
  input wire logic capture_flag_i,
  input wire logic break_active_i,
  input wire logic [3:0] break_pattern_i,
  output logic [7:0] rdata_o,
  output logic capture_event_o,
  output logic overflow_two_irq_o,
  output logic [3:0] pwm_o
);
  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] csr2;
    logic [1:0] brken;
    logic [11:0] rld1;
    logic [11:0] rld2;
    logic [7:0] dead;
    logic [11:0] cnt1;
    logic [11:0] cnt2;
    logic [11:0] cap;
    logic cap_ev;
    logic pin_q;
    logic ovf1_q;
    logic overflow_two_flag_q;
    logic [3:0][11:0] duty_pre;
    logic [3:0][11:0] duty_act;
    logic [3:0] pol_pre;
    logic [3:0] pol_act;
    logic [3:0] pwm;
    logic [6:0] dt_cnt;
    arpw_dt_type dt_st;
    logic lvl0_q;
  } arpw_state_type;
  arpw_state_type st;
  arpw_state_type next_st;
  arpw_bus_type bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  logic pin_now;
  logic ovf1;
  logic overflow_two_flag;
  logic sel2;
  logic [3:0] raw;
  logic [3:0] brk;
  // ******************************
  // combinational helpers
  // ******************************
  // capture pin mux
  assign pin_now = st.csr2[`ARPW_CSR2_ICS] ? lite_capture_pin_i
                                            : timer_capture_pin_i;
  assign sel2 = st.csr2[`ARPW_CSR2_SEL2];
  assign ovf1 = tick1_i && (st.cnt1 == `ARPW_CNT_FULL);
  // counter 2 only ticks while selected
  assign overflow_two_flag = tick2_i && sel2 && (st.cnt2 == `ARPW_CNT_FULL);
  // raw compare outputs, channels 2/3 on selected counter
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      // period follows counter 2 only when selected
      logic [CW-1:0] cv;
      assign cv = (gi >= 2 && sel2) ? st.cnt2 : st.cnt1;
      assign raw[gi] = (cv < st.duty_act[gi]) ^ st.pol_act[gi];
      // counter-1 break on 0/1 and unselected 2/3
      assign brk[gi] = break_active_i &&
        ((gi < 2 || !sel2) ? st.brken[0] : st.brken[1]);
    end
  endgenerate
  // ******************************
  // next state
  // ******************************
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.cap_ev = 1'b0;
    next_st.pin_q = pin_now;
    next_st.ovf1_q = ovf1;
    next_st.overflow_two_flag_q = overflow_two_flag;
    // counter 1 with reload
    if (tick1_i) begin
      next_st.cnt1 = ovf1 ? st.rld1 : st.cnt1 + 12'h001;
    end
    // counter 2 reload on overflow, frozen when unselected
    if (tick2_i && sel2) begin
      next_st.cnt2 = overflow_two_flag ? st.rld2 : st.cnt2 + 12'h001;
    end
    // force one loads full count, cleared after overflow
    if (st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_ONE] && !st.ovf1_q && !ovf1) begin
      next_st.cnt1 = `ARPW_CNT_FULL;
    end
    if (st.ovf1_q) begin
      next_st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_ONE] = 1'b0;
    end
    // force two loads full count, cleared after overflow
    if (st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO] && !st.overflow_two_flag_q && !overflow_two_flag) begin
      next_st.cnt2 = `ARPW_CNT_FULL;
    end
    if (st.overflow_two_flag_q) begin
      next_st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO] = 1'b0;
    end
    if ((pin_now != st.pin_q) && !capture_flag_i) begin
      next_st.cap = st.cnt1;
      next_st.cap_ev = 1'b1;
    end
    // register reads; reading status clears the overflow flag
    if (bus.rd) begin
      unique case (bus.addr)
        `ARPW_OFF_CAP_HIGH: next_st.rdata = {4'h0, st.cap[11:8]};
        `ARPW_OFF_CAP_LOW: next_st.rdata = st.cap[7:0];
        `ARPW_OFF_CSR2: begin
          next_st.rdata = st.csr2;
          next_st.csr2[`ARPW_CSR2_OVERFLOW_TWO_FLAG] = 1'b0;
        end
        `ARPW_OFF_RLD2_HIGH: next_st.rdata = {4'h0, st.rld2[11:8]};
        `ARPW_OFF_RLD2_LOW: next_st.rdata = st.rld2[7:0];
        `ARPW_OFF_DEAD: next_st.rdata = st.dead;
        `ARPW_OFF_BRKEN: next_st.rdata = {6'h00, st.brken};
        `ARPW_OFF_POL: next_st.rdata = {4'h0, st.pol_pre};
        `ARPW_OFF_RLD1_HIGH: next_st.rdata = {4'h0, st.rld1[11:8]};
        `ARPW_OFF_RLD1_LOW: next_st.rdata = st.rld1[7:0];
        `ARPW_OFF_CNT2_HIGH: next_st.rdata = {4'h0, st.cnt2[11:8]};
        `ARPW_OFF_CNT2_LOW: next_st.rdata = st.cnt2[7:0];
        default: next_st.rdata = 8'h00;
      endcase
    end
    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `ARPW_OFF_CSR2: begin
          // zero writes to force/transfer bits are ignored
          next_st.csr2[7:6] = st.csr2[7:6] | bus.wdata[7:6];
          next_st.csr2[5:4] = bus.wdata[5:4];
          next_st.csr2[2] = bus.wdata[2];
          next_st.csr2[1:0] = st.csr2[1:0] | bus.wdata[1:0];
        end
        `ARPW_OFF_RLD2_HIGH: next_st.rld2[11:8] = bus.wdata[3:0];
        `ARPW_OFF_RLD2_LOW: next_st.rld2[7:0] = bus.wdata;
        `ARPW_OFF_DEAD: next_st.dead = bus.wdata;
        `ARPW_OFF_BRKEN: next_st.brken = bus.wdata[1:0];
        `ARPW_OFF_POL: next_st.pol_pre = bus.wdata[3:0];
        `ARPW_OFF_RLD1_HIGH: next_st.rld1[11:8] = bus.wdata[3:0];
        `ARPW_OFF_RLD1_LOW: next_st.rld1[7:0] = bus.wdata;
        default: begin
          // duty preload: two bytes per channel, high then low
          for (int i = 0; i < 4; i++) begin
            if (bus.addr == `ARPW_OFF_DUTY0 + 8'(2 * i)) begin
              next_st.duty_pre[i][11:8] = bus.wdata[3:0];
            end
            if (bus.addr == `ARPW_OFF_DUTY0 + 8'(2 * i + 1)) begin
              next_st.duty_pre[i][7:0] = bus.wdata;
            end
          end
        end
      endcase
    end
    // overflow flag set wins over the read clear
    if (overflow_two_flag) begin
      next_st.csr2[`ARPW_CSR2_OVERFLOW_TWO_FLAG] = 1'b1;
    end
    if (ovf1 && st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_ONE]) begin
      for (int i = 0; i < 4; i++) begin
        if (i < 2 || !sel2) begin
          next_st.duty_act[i] = st.duty_pre[i];
          next_st.pol_act[i] = st.pol_pre[i];
        end
      end
      next_st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_ONE] = 1'b0;
    end
    if (overflow_two_flag && st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_TWO]) begin
      for (int i = 2; i < 4; i++) begin
        next_st.duty_act[i] = st.duty_pre[i];
        next_st.pol_act[i] = st.pol_pre[i];
      end
      next_st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_TWO] = 1'b0;
    end
    // outputs 2/3 and default 0/1 with break pattern
    for (int i = 0; i < 4; i++) begin
      next_st.pwm[i] = brk[i] ? break_pattern_i[i] : raw[i];
    end
    next_st.lvl0_q = raw[0];
    if (st.dead[`ARPW_DEAD_EN]) begin
      if (st.dead[6:0] == 7'h00) begin
        next_st.pwm[1:0] = 2'b00;
        next_st.dt_st = ARPW_DT_IDLE;
      end else begin
        unique case (st.dt_st)
          ARPW_DT_IDLE, ARPW_DT_RUN: begin
            if (raw[0] != st.lvl0_q) begin
              next_st.dt_st = ARPW_DT_WAIT;
              next_st.dt_cnt = st.dead[6:0];
            end
          end
          ARPW_DT_WAIT: begin
            if (tick1_i) begin
              next_st.dt_cnt = st.dt_cnt - 7'h01;
              if (st.dt_cnt == 7'h01) begin
                next_st.dt_st = ARPW_DT_RUN;
              end
            end
          end
        endcase
        // both low during the gap; channel 1 is channel 0 inverted
        if (next_st.dt_st == ARPW_DT_WAIT) begin
          next_st.pwm[1:0] = 2'b00;
        end else begin
          next_st.pwm[0] = brk[0] ? break_pattern_i[0] : raw[0];
          next_st.pwm[1] = brk[1] ? break_pattern_i[1] : !raw[0];
        end
      end
    end
  end
  // ******************************
  // registers
  // ******************************
  // clock enable freezes everything
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      // constants only: later field writes override the zero fill
      st <= '0;
      st.csr2 <= `ARPW_RST_CSR2;
      st.brken <= `ARPW_RST_BRKEN;
      st.dt_st <= ARPW_DT_IDLE;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end
  assign rdata_o = st.rdata;
  assign capture_event_o = st.cap_ev;
  // irq gated by enable and flag
  assign overflow_two_irq_o = st.csr2[`ARPW_CSR2_OVERFLOW_TWO_IRQ_ENABLE] &&
                              st.csr2[`ARPW_CSR2_OVERFLOW_TWO_FLAG];
  assign pwm_o = st.pwm;
  // ******************************
  // checks
  // ******************************
  // one clock domain, so one default clock and reset for every check
  default clocking cb_chk @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  a_ovf_flag_set: assert property (
    clk_en_i && overflow_two_flag |=> st.csr2[`ARPW_CSR2_OVERFLOW_TWO_FLAG])
    else $error("overflow two flag not set");
  a_irq_gate_two: assert property (
    overflow_two_irq_o |-> st.csr2[`ARPW_CSR2_OVERFLOW_TWO_IRQ_ENABLE])
    else $error("irq without enable");
  a_cnt2_freeze: assert property (
    clk_en_i && !sel2 && !st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO] |=> $stable(st.cnt2))
    else $error("counter two moved while unselected");
  a_cnt2_step: assert property (
    clk_en_i && sel2 && tick2_i && !overflow_two_flag && !st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO]
    |=> st.cnt2 == $past(st.cnt2) + 12'h001)
    else $error("counter two did not step from held value");
  a_cap_blocked: assert property (
    clk_en_i && capture_flag_i |=> !st.cap_ev)
    else $error("capture while flag set");
  a_cap_copy: assert property (
    clk_en_i && (pin_now != st.pin_q) && !capture_flag_i
    |=> st.cap_ev && st.cap == $past(st.cnt1))
    else $error("capture did not copy counter one");
  a_cap_src_lite: assert property (
    clk_en_i && st.csr2[`ARPW_CSR2_ICS] &&
    (lite_capture_pin_i == st.pin_q) |=> !st.cap_ev)
    else $error("capture without lite pin edge");
  a_cnt2_reload: assert property (
    clk_en_i && overflow_two_flag && !st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO]
    |=> st.cnt2 == $past(st.rld2))
    else $error("counter two not reloaded");
  a_transfer_enable_two_clear: assert property (
    clk_en_i && overflow_two_flag |=> !st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_TWO] || $past(bus.wr))
    else $error("transfer two not cleared");
  a_transfer_enable_two_move: assert property (
    clk_en_i && overflow_two_flag && st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_TWO]
    |=> st.duty_act[2] == $past(st.duty_pre[2]))
    else $error("channel two duty not transferred");
  a_transfer_enable_one_clear: assert property (
    clk_en_i && ovf1 && !bus.wr |=> !st.csr2[`ARPW_CSR2_TRANSFER_ENABLE_ONE])
    else $error("transfer one not cleared");
  a_force_overflow_two_load: assert property (
    clk_en_i && st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO] && !st.overflow_two_flag_q && !overflow_two_flag
    |=> st.cnt2 == `ARPW_CNT_FULL)
    else $error("force two did not load full count");
  a_force_overflow_two_clear: assert property (
    clk_en_i && st.overflow_two_flag_q && !bus.wr |=> !st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_TWO])
    else $error("force two not cleared");
  a_force_overflow_one_load: assert property (
    clk_en_i && st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_ONE] && !st.ovf1_q && !ovf1
    |=> st.cnt1 == `ARPW_CNT_FULL)
    else $error("force one did not load full count");
  a_force_overflow_one_clear: assert property (
    clk_en_i && st.ovf1_q && !bus.wr |=> !st.csr2[`ARPW_CSR2_FORCE_OVERFLOW_ONE])
    else $error("force one not cleared");
  a_flag_read_clr: assert property (
    clk_en_i && bus.rd && (bus.addr == `ARPW_OFF_CSR2) && !overflow_two_flag
    |=> !st.csr2[`ARPW_CSR2_OVERFLOW_TWO_FLAG])
    else $error("status read left overflow flag set");
  a_pwm2_cnt2: assert property (
    clk_en_i && sel2 && !brk[2]
    |=> pwm_o[2] == $past((st.cnt2 < st.duty_act[2]) ^ st.pol_act[2]))
    else $error("channel two not driven by counter two");
  a_pwm3_cnt1: assert property (
    clk_en_i && !sel2 && !brk[3]
    |=> pwm_o[3] == $past((st.cnt1 < st.duty_act[3]) ^ st.pol_act[3]))
    else $error("channel three not driven by counter one");
  a_brk_two_sel: assert property (
    clk_en_i && sel2 && break_active_i && st.brken[1]
    |=> pwm_o[3:2] == $past(break_pattern_i[3:2]))
    else $error("counter two break not applied");
  a_brk_one: assert property (
    clk_en_i && break_active_i && st.brken[0] && !st.dead[`ARPW_DEAD_EN]
    |=> pwm_o[1:0] == $past(break_pattern_i[1:0]))
    else $error("counter one break not applied");
  a_dead_gap: assert property (
    clk_en_i && st.dead[`ARPW_DEAD_EN] && (st.dead[6:0] != 7'h00) &&
    (next_st.dt_st == ARPW_DT_WAIT) |=> pwm_o[1:0] == 2'b00)
    else $error("channel 0/1 active inside dead time");
  a_dead_load: assert property (
    clk_en_i && st.dead[`ARPW_DEAD_EN] && (st.dead[6:0] != 7'h00) &&
    (st.dt_st != ARPW_DT_WAIT) && (raw[0] != st.lvl0_q)
    |=> st.dt_cnt == $past(st.dead[6:0]))
    else $error("dead time count not loaded");
  a_dead_len: assert property (
    clk_en_i && st.dead[`ARPW_DEAD_EN] && (st.dead[6:0] != 7'h00) &&
    (st.dt_st == ARPW_DT_WAIT) && tick1_i && (st.dt_cnt == 7'h01)
    |=> st.dt_st == ARPW_DT_RUN)
    else $error("dead time did not end on last tick");
  a_dead_zero: assert property (
    clk_en_i && st.dead == 8'h80 ##1 st.dead == 8'h80 |-> pwm_o[1:0] == 2'b00)
    else $error("outputs active with zero dead time");
  a_brk_rsvd: assert property (
    clk_en_i && bus.rd && (bus.addr == `ARPW_OFF_BRKEN)
    |=> rdata_o[7:2] == 6'h00)
    else $error("reserved break enable bits not zero");
  // low clock enable must freeze every state bit
  a_freeze_all: assert property (
    !clk_en_i |=> $stable(st))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* test/test_arpw_top.sv */
// self-checking testbench for the pwm block
`timescale 1ns/1ps
`default_nettype none
`include "arpw_regs.svh"
module test_arpw_top;
  import arpw_pkg::*;
  // ************************************************************
  // signals and clock
  // ************************************************************
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tick1_i = 1'b0;
  logic tick2_i = 1'b0;
  logic tpin = 1'b0;
  logic lpin = 1'b0;
  logic cflag = 1'b0;
  logic brk = 1'b0;
  logic [3:0] brk_pat = 4'ha;
  logic cen = 1'b1;
  logic [7:0] rdata_o;
  logic capture_event_o;
  logic overflow_two_irq_o;
  logic [3:0] pwm_o;
  int bad_count = 0;
  int n_checks = 0;
  int cap_n = 0;
  logic [7:0] rv;
  always #10 mclk_i = ~mclk_i;
  arpw_top u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(cen),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .tick1_i(tick1_i), .tick2_i(tick2_i), .timer_capture_pin_i(tpin),
    .lite_capture_pin_i(lpin), .capture_flag_i(cflag),
    .break_active_i(brk), .break_pattern_i(brk_pat), .rdata_o(rdata_o),
    .capture_event_o(capture_event_o),
    .overflow_two_irq_o(overflow_two_irq_o), .pwm_o(pwm_o));
  // count capture pulses so a missed or extra one shows up
  always @(posedge mclk_i) begin
    if (capture_event_o === 1'b1) cap_n <= cap_n + 1;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rd12(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 8'h01, l);
    v = {4'h0, h[3:0], l};
  endtask
  task automatic tick(input int n, input bit two);
    repeat (n) begin
      @(posedge mclk_i);
      if (two) tick2_i <= 1'b1;
      else tick1_i <= 1'b1;
      @(posedge mclk_i);
      tick1_i <= 1'b0;
      tick2_i <= 1'b0;
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic pin(input bit lite);
    @(posedge mclk_i);
    if (lite) lpin <= ~lpin;
    else tpin <= ~tpin;
    wait_n(4);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_regs;
    rd(`ARPW_OFF_CSR2, rv);
    chk("csr2 reset", 16'h0003, {8'h0, rv});
    rd(`ARPW_OFF_CAP_LOW, rv);
    chk("capture reset", 16'h0000, {8'h0, rv});
    rd(`ARPW_OFF_DEAD, rv);
    chk("dead reset", 16'h0000, {8'h0, rv});
    rd(`ARPW_OFF_RLD2_LOW, rv);
    chk("reload2 reset", 16'h0000, {8'h0, rv});
    rd(8'hff, rv);
    chk("unmapped read", 16'h0000, {8'h0, rv});
    rd(`ARPW_OFF_BRKEN, rv);
    chk("brken reset", 16'h0003, {8'h0, rv});
    // reserved bits stay zero
    wr(`ARPW_OFF_BRKEN, 8'hfe);
    rd(`ARPW_OFF_BRKEN, rv);
    chk("brken reserved", 16'h0002, {8'h0, rv});
  endtask
  task automatic t_capture;
    logic [15:0] v;
    tick(5, 1'b0);
    pin(1'b0);
    chk("capture pulse", 16'd1, 16'(cap_n));
    rd12(`ARPW_OFF_CAP_HIGH, v);
    chk("capture value", 16'd5, v);
    // flag set blocks capture and keeps old value
    @(posedge mclk_i);
    cflag <= 1'b1;
    tick(2, 1'b0);
    pin(1'b0);
    chk("blocked pulse", 16'd1, 16'(cap_n));
    rd12(`ARPW_OFF_CAP_HIGH, v);
    chk("blocked value", 16'd5, v);
    @(posedge mclk_i);
    cflag <= 1'b0;
    // source select moves capture to the lite pin
    wr(`ARPW_OFF_CSR2, 8'h20);
    pin(1'b0);
    chk("own pin ignored", 16'd1, 16'(cap_n));
    pin(1'b1);
    chk("lite pin taken", 16'd2, 16'(cap_n));
    rd12(`ARPW_OFF_CAP_HIGH, v);
    chk("lite value", 16'd7, v);
  endtask
  task automatic t_counter2;
    logic [15:0] v;
    wr(`ARPW_OFF_RLD2_HIGH, 8'h01);
    wr(`ARPW_OFF_RLD2_LOW, 8'h23);
    wr(`ARPW_OFF_CSR2, 8'h94);
    tick(1, 1'b1);
    wait_n(3);
    chk("irq raised", 16'd1, {15'h0, overflow_two_irq_o});
    rd12(`ARPW_OFF_CNT2_HIGH, v);
    chk("reload taken", 16'h0123, v);
    // force and transfer two cleared, flag set
    rd(`ARPW_OFF_CSR2, rv);
    chk("csr2 after ovf", 16'h001d, {8'h0, rv});
    wait_n(1);
    chk("irq after read", 16'd0, {15'h0, overflow_two_irq_o});
    rd(`ARPW_OFF_CSR2, rv);
    chk("flag cleared", 16'h0015, {8'h0, rv});
    // counter two holds while unselected
    // status writes only ever set force and transfer bits
    wr(`ARPW_OFF_CSR2, 8'h10);
    tick(3, 1'b1);
    rd12(`ARPW_OFF_CNT2_HIGH, v);
    chk("frozen count", 16'h0123, v);
    wr(`ARPW_OFF_CSR2, 8'h14);
    tick(2, 1'b1);
    rd12(`ARPW_OFF_CNT2_HIGH, v);
    chk("resumed count", 16'h0125, v);
    // overflow with the interrupt masked
    wr(`ARPW_OFF_CSR2, 8'h84);
    tick(1, 1'b1);
    wait_n(3);
    chk("irq masked", 16'd0, {15'h0, overflow_two_irq_o});
    rd(`ARPW_OFF_CSR2, rv);
    chk("masked flag", 16'h000d, {8'h0, rv});
  endtask
  // clock enable low must hold counter two through ticks
  task automatic t_freeze;
    logic [15:0] v;
    @(posedge mclk_i);
    cen <= 1'b0;
    tick(3, 1'b1);
    @(posedge mclk_i);
    cen <= 1'b1;
    rd12(`ARPW_OFF_CNT2_HIGH, v);
    chk("frozen by enable", 16'h0123, v);
  endtask
  // channels 2/3 on counter 2, transfer two, break two, dead gap length
  task automatic t_chan23;
    wr(`ARPW_OFF_DEAD, 8'h00);
    wr(`ARPW_OFF_DUTY0 + 8'h04, 8'h01);
    wr(`ARPW_OFF_CSR2, 8'h86);
    tick(1, 1'b1);
    wait_n(3);
    chk("chan2 on counter2", 16'h0001, {12'h0, pwm_o});
    rd(`ARPW_OFF_CSR2, rv);
    chk("transfer_enable_two cleared", 16'h000c, {8'h0, rv});
    wr(`ARPW_OFF_CSR2, 8'h00);
    wait_n(3);
    chk("chan2 on counter1", 16'h0005, {12'h0, pwm_o});
    wr(`ARPW_OFF_CSR2, 8'h04);
    brk <= 1'b1;
    wait_n(3);
    chk("break two sel", 16'h0009, {12'h0, pwm_o});
    @(posedge mclk_i);
    brk <= 1'b0;
    // force-one load of FFFh drops channel 0 and opens a two-tick gap; polarity flip keeps it low
    wr(`ARPW_OFF_DEAD, 8'h82);
    wr(`ARPW_OFF_POL, 8'h01);
    wr(`ARPW_OFF_CSR2, 8'h45);
    tick(1, 1'b0);
    wait_n(2);
    chk("dead gap open", 16'h0000, {12'h0, pwm_o});
    tick(1, 1'b0);
    wait_n(1);
    chk("dead gap one tick", 16'h0000, {12'h0, pwm_o});
    tick(1, 1'b0);
    wait_n(2);
    chk("dead gap closed", 16'h0002, {12'h0, pwm_o});
  endtask
  task automatic t_pwm;
    wr(`ARPW_OFF_DUTY0, 8'h08);
    wr(`ARPW_OFF_DUTY0 + 8'h01, 8'h00);
    wr(`ARPW_OFF_CSR2, 8'h40);
    tick(1, 1'b0);
    wait_n(3);
    rd(`ARPW_OFF_CSR2, rv);
    chk("force_overflow_one transfer_enable_one clear", 16'h0000, {8'h0, rv});
    wait_n(2);
    chk("duty moved", 16'h0001, {12'h0, pwm_o});
    // break through counter one covers all four while unselected
    wr(`ARPW_OFF_BRKEN, 8'h01);
    brk <= 1'b1;
    wait_n(3);
    chk("break one", 16'h000a, {12'h0, pwm_o});
    wr(`ARPW_OFF_BRKEN, 8'h02);
    wait_n(3);
    chk("break two unsel", 16'h0001, {12'h0, pwm_o});
    @(posedge mclk_i);
    brk <= 1'b0;
    wr(`ARPW_OFF_DEAD, 8'h83);
    wait_n(10);
    chk("dead steady", 16'h0001, {12'h0, pwm_o});
    // enabled with zero count parks outputs 0/1 at reset level
    wr(`ARPW_OFF_DEAD, 8'h80);
    wait_n(3);
    chk("dead zero", 16'h0000, {12'h0, pwm_o});
  endtask
  // ************************************************************
  // sequence, watchdog and verdict
  // ************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset_regs();
    t_capture();
    t_counter2();
    t_freeze();
    t_pwm();
    t_chan23();
    wrap_up();
  end
  // the tests need well under a thousand cycles; allow far more
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
